// ==== pkg/sbr_pkg.sv ====
package sbr_pkg;

  localparam int SBR_GROUPS = 8;
  localparam int SBR_BITS = 32;
  localparam int SBR_GROUP_W = 4;

  localparam int SBR_CLK_HZ = 20000000;
  // Base reading period is one fifth of a second.
  localparam int SBR_BASE_MS = 200;
  localparam int SBR_BASE_CYC = SBR_CLK_HZ / 1000 * SBR_BASE_MS;
  // Flag stands at least this long in each update taken outside output hold.
  localparam int SBR_FLAG_MS = 50;
  localparam int SBR_FLAG_CYC = SBR_CLK_HZ / 1000 * SBR_FLAG_MS;
  // Rate setting runs 1 to 35 base periods: 0.2 s up to 7 s.
  localparam int SBR_RATE_MIN = 1;
  localparam int SBR_RATE_MAX = 35;
  localparam logic [5:0] SBR_RATE_RST = 6'h01;

  typedef struct packed {
    logic [3:0] func;
    logic exp_pol;
    logic exp_tens;
    logic [3:0] exp_units;
    logic [3:0] digit0;
    logic [3:0] digit1;
    logic [3:0] digit2;
    logic [1:0] range_dir;
    logic digit3;
    logic polarity;
    logic [1:0] dp_low;
    logic [3:0] dp_high;
  } sbr_reading_t;

  typedef struct packed {
    logic [SBR_BITS-1:0] lvl;
    logic [SBR_BITS-1:0] oe;
  } sbr_pins_t;

endpackage : sbr_pkg

// ==== logic/sbr_rate_timer.sv ====
`timescale 1ns/100ps
module sbr_rate_timer
  import sbr_pkg::*;
#(
  parameter int BASE_CYC = SBR_BASE_CYC
) (
  input wire logic sys_clk_in, // Clock.
  input wire logic srst_in, // Synchronous reset.
  input wire logic [5:0] rate_in, // Base periods per update.
  output logic base_tick_out, // One pulse per base period.
  output logic update_out // One pulse per output update.
);

  logic [31:0] base_cnt_r, base_cnt_nxt;
  logic [5:0] per_cnt_r, per_cnt_nxt;
  logic [5:0] rate_lim;

  always_comb begin
    rate_lim = rate_in;
    if (rate_in < 6'(SBR_RATE_MIN)) begin
      rate_lim = 6'(SBR_RATE_MIN);
    end else if (rate_in > 6'(SBR_RATE_MAX)) begin
      rate_lim = 6'(SBR_RATE_MAX);
    end
    base_tick_out = (base_cnt_r == 32'(BASE_CYC - 1));
    base_cnt_nxt = base_tick_out ? 32'h0 : base_cnt_r + 32'h1;
    per_cnt_nxt = per_cnt_r;
    update_out = 1'b0;
    if (base_tick_out) begin
      if (per_cnt_r + 6'h01 >= rate_lim) begin
        per_cnt_nxt = 6'h00;
        update_out = 1'b1;
      end else begin
        per_cnt_nxt = per_cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      base_cnt_r <= 32'h0;
      per_cnt_r <= 6'h00;
    end else begin
      base_cnt_r <= base_cnt_nxt;
      per_cnt_r <= per_cnt_nxt;
    end
  end

  update_period_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    (per_cnt_r < 6'(SBR_RATE_MAX)))
    else $error("period count beyond the longest interval");

endmodule : sbr_rate_timer

// ==== logic/sbr_reading_port.sv ====
`timescale 1ns/100ps
module sbr_reading_port
  import sbr_pkg::*;
#(
  parameter int BASE_CYC = SBR_BASE_CYC,
  parameter int FLAG_CYC = SBR_FLAG_CYC
) (
  input wire logic sys_clk_in, // 20 MHz clock.
  input wire logic srst_in, // Synchronous reset, high.
  input wire sbr_reading_t reading_in, // Latest conversion result.
  input wire logic [5:0] rate_in, // Update interval in 0.2 s steps.
  input wire logic [7:0] strobe_n_in, // Group strobes, active low, pins.
  input wire logic out_hold_n_in, // Output hold, active low, pin.
  input wire logic disp_hold_n_in, // Display hold, active low, pin.
  input wire logic zero_chk_n_in, // Remote offset check, active low, pin.
  input wire logic man_range_n_in, // Manual sensitivity, active low, pin.
  input wire logic [2:0] range_sel_in, // Coded sensitivity lines, pin.
  output sbr_pins_t pins_out, // Open-collector levels and enables.
  output logic flag_out, // Timing flag, data stable while high.
  output logic flag_n_out, // Inverted timing flag.
  output logic disp_hold_out, // Display hold request to the meter.
  output logic zero_chk_out, // Offset check request to the meter.
  output logic man_range_out, // Remote sensitivity selection enabled.
  output logic [2:0] range_out // Remote sensitivity code.
);

  logic [7:0] stb_s1_r, stb_s2_r;
  logic [3:0] ctl_s1_r, ctl_s2_r;
  logic [2:0] rng_s1_r, rng_s2_r;
  logic [SBR_BITS-1:0] data_r, data_nxt;
  logic [SBR_BITS-1:0] oe_r, oe_nxt;
  logic [SBR_BITS-1:0] drive_r, drive_nxt;
  logic flag_r, flag_nxt;
  logic [31:0] flag_cnt_r, flag_cnt_nxt;
  logic base_tick, update;
  logic [31:0] upd_gap_r, upd_gap_nxt;
  logic [31:0] flag_len_r, flag_len_nxt;

  // Pins cross into the clock domain through two flops before any use.
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      stb_s1_r <= 8'hff;
      stb_s2_r <= 8'hff;
      ctl_s1_r <= 4'hf;
      ctl_s2_r <= 4'hf;
      rng_s1_r <= 3'h0;
      rng_s2_r <= 3'h0;
    end else begin
      stb_s1_r <= strobe_n_in;
      stb_s2_r <= stb_s1_r;
      ctl_s1_r <= {out_hold_n_in, disp_hold_n_in, zero_chk_n_in,
                   man_range_n_in};
      ctl_s2_r <= ctl_s1_r;
      rng_s1_r <= range_sel_in;
      rng_s2_r <= rng_s1_r;
    end
  end

  sbr_rate_timer #(
    .BASE_CYC(BASE_CYC)
  ) u_timer (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .rate_in(rate_in),
    .base_tick_out(base_tick),
    .update_out(update)
  );

  // Each group's 4 enables follow its own strobe.
  function automatic logic [SBR_BITS-1:0] group_oe(input logic [7:0] stb_n);
    logic [SBR_BITS-1:0] m;
    m = '0;
    for (int g = 0; g < SBR_GROUPS; g++) begin
      m[g*SBR_GROUP_W +: SBR_GROUP_W] = {SBR_GROUP_W{~stb_n[g]}};
    end
    return m;
  endfunction : group_oe

  always_comb begin
    data_nxt = data_r;
    flag_nxt = flag_r;
    flag_cnt_nxt = flag_cnt_r;
    // The data word changes only at an update; the flag then stands for
    // a fixed time so the far side has a quiet window to sample in.
    if (update && ctl_s2_r[3]) begin
      data_nxt = reading_in;
      flag_nxt = 1'b1;
      flag_cnt_nxt = 32'(FLAG_CYC - 1);
    end else if (flag_r) begin
      if (flag_cnt_r == 32'h0) begin
        flag_nxt = 1'b0;
      end else begin
        flag_cnt_nxt = flag_cnt_r - 32'h1;
      end
    end
    oe_nxt = group_oe(stb_s2_r);
    drive_nxt = oe_nxt & ~data_nxt;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      data_r <= '0;
      oe_r <= '0;
      drive_r <= '0;
      flag_r <= 1'b0;
      flag_cnt_r <= 32'h0;
    end else begin
      data_r <= data_nxt;
      oe_r <= oe_nxt;
      drive_r <= drive_nxt;
      flag_r <= flag_nxt;
      flag_cnt_r <= flag_cnt_nxt;
    end
  end

  // Open collector: a driven bit pulls low when the data bit is 0, and
  // never drives a high, so several units can share the lines. The enable
  // is a flop of its own so the pins cannot glitch as strobes move.
  assign pins_out = {{SBR_BITS{1'b0}}, drive_r};
  assign flag_out = flag_r;
  assign flag_n_out = ~flag_r;
  assign disp_hold_out = ~ctl_s2_r[2];
  assign zero_chk_out = ~ctl_s2_r[1];
  assign man_range_out = ~ctl_s2_r[0];
  assign range_out = rng_s2_r;

  // Checker helpers: cycles since the last update, and how long the flag
  // has stood so far. Nothing but the assertions below reads them.
  always_comb begin
    upd_gap_nxt = update ? 32'h0 : upd_gap_r + 32'h1;
    flag_len_nxt = flag_r ? flag_len_r + 32'h1 : 32'h0;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      upd_gap_r <= 32'h0;
      flag_len_r <= 32'h0;
    end else begin
      upd_gap_r <= upd_gap_nxt;
      flag_len_r <= flag_len_nxt;
    end
  end

  unstrobed_quiet_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    (&stb_s2_r) |=> (pins_out.oe == '0))
    else $error("unstrobed unit drives the bus");

  group_enable_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    !stb_s2_r[0] |=> (oe_r[3:0] == 4'hf))
    else $error("strobed group not enabled");

  all_strobes_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    (stb_s2_r == 8'h00) |=> (&oe_r))
    else $error("full parallel enable missing");

  full_drive_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    (&oe_r) |-> (pins_out.oe == ~data_r))
    else $error("enabled outputs do not follow the data");

  flag_stable_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    (flag_r && $past(flag_r)) |-> $stable(data_r))
    else $error("data changed while flag high");

  flag_width_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    $fell(flag_r) |-> (flag_len_r == 32'(FLAG_CYC)))
    else $error("flag stood for the wrong time");

  hold_keeps_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    !ctl_s2_r[3] |=> $stable(data_r))
    else $error("data changed under output hold");

  hold_no_flag_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    (update && !ctl_s2_r[3]) |=> !$rose(flag_r))
    else $error("flag raised under output hold");

  update_load_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    (update && ctl_s2_r[3]) |=> (flag_r && data_r == $past(reading_in)))
    else $error("update did not load reading");

  flag_rise_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    $rose(flag_r) |-> $past(update))
    else $error("flag rose without an update");

  base_tick_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    update |-> base_tick)
    else $error("update off the base period");

  update_step_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    update |-> ((upd_gap_r + 32'h1) % 32'(BASE_CYC) == 32'h0))
    else $error("update interval not whole base periods");

  update_bound_a: assert property (@(posedge sys_clk_in)
    disable iff (srst_in)
    update |-> (upd_gap_r >= 32'(BASE_CYC - 1) &&
                upd_gap_r < 32'(SBR_RATE_MAX * BASE_CYC)))
    else $error("update interval out of range");

endmodule : sbr_reading_port

// ==== bench/sbr_daq_model.sv ====
`timescale 1ns/100ps
module sbr_daq_model
  import sbr_pkg::*;
(
  input wire sbr_pins_t pins_in, // Unit open-collector pins.
  output logic [SBR_BITS-1:0] bus_out // Shared bus with pull-ups.
);
  // A released line floats up to the pull-up level, so it reads one.
  always_comb begin
    for (int b = 0; b < SBR_BITS; b++) begin
      bus_out[b] = (pins_in.oe[b] === 1'b1) ? pins_in.lvl[b] : 1'b1;
    end
  end
endmodule : sbr_daq_model

// ==== bench/strobed_bcd_reading_output_test.sv ====
`timescale 1ns/100ps
module strobed_bcd_reading_output_test;
  import sbr_pkg::*;
  localparam int BASE = 20;
  localparam int FLAGW = 5;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  sbr_reading_t reading_in = '0;
  logic [5:0] rate_in = 6'h02;
  logic [7:0] strobe_n_in = 8'hff;
  logic out_hold_n_in = 1'b1;
  logic disp_hold_n_in = 1'b1;
  logic zero_chk_n_in = 1'b1;
  logic man_range_n_in = 1'b1;
  logic [2:0] range_sel_in = 3'h0;
  sbr_pins_t pins_out;
  logic flag_out, flag_n_out, disp_hold_out, zero_chk_out, man_range_out;
  logic [2:0] range_out;
  logic [SBR_BITS-1:0] bus;
  logic [15:0] lfsr = 16'hd307;
  logic [31:0] pend[$];
  logic [31:0] exp_data = 32'h0;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int gap;
  int w;

  sbr_reading_port #(.BASE_CYC(BASE), .FLAG_CYC(FLAGW)) dut (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .reading_in(reading_in),
    .rate_in(rate_in), .strobe_n_in(strobe_n_in),
    .out_hold_n_in(out_hold_n_in), .disp_hold_n_in(disp_hold_n_in),
    .zero_chk_n_in(zero_chk_n_in), .man_range_n_in(man_range_n_in),
    .range_sel_in(range_sel_in), .pins_out(pins_out), .flag_out(flag_out),
    .flag_n_out(flag_n_out), .disp_hold_out(disp_hold_out),
    .zero_chk_out(zero_chk_out), .man_range_out(man_range_out),
    .range_out(range_out));
  sbr_daq_model u_daq (.pins_in(pins_out), .bus_out(bus));

  always #25 sys_clk_in = ~sys_clk_in;

  task automatic complete_run();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic new_reading();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    reading_in[31:16] = lfsr;
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    reading_in[15:0] = lfsr;
    // Digit fields are kept to legal BCD codes, as a conversion gives.
    reading_in.exp_units = reading_in.exp_units % 4'ha;
    reading_in.digit0 = reading_in.digit0 % 4'ha;
    reading_in.digit1 = reading_in.digit1 % 4'ha;
    reading_in.digit2 = reading_in.digit2 % 4'ha;
    pend.push_back(reading_in);
  endtask : new_reading

  // Counts from one flag rise to the next; the newest reading then shows.
  task automatic wait_flag(output int n);
    logic seen_low;
    seen_low = 1'b0;
    n = 0;
    do begin
      tick();
      n++;
      if (flag_out !== 1'b1) seen_low = 1'b1;
    end while (!(seen_low && flag_out === 1'b1) && n < 800);
    if (n < 800 && pend.size() > 0) begin
      exp_data = pend[$];
      pend.delete();
    end
  endtask : wait_flag

  task automatic show(input logic [7:0] s);
    logic [31:0] e;
    logic [31:0] eoe;
    strobe_n_in = s;
    repeat (4) tick();
    for (int b = 0; b < 32; b++) begin
      e[b] = s[b / 4] ? 1'b1 : exp_data[b];
      eoe[b] = ~s[b / 4] & ~exp_data[b];
    end
    chk(bus, e);
    chk(pins_out.oe, eoe);
    chk({31'h0, flag_n_out}, {31'h0, ~flag_out});
  endtask : show

  initial begin
    repeat (15) tick();
    chk(pins_out.oe, 32'h0);
    chk({flag_out, flag_n_out}, 32'h1);
    tick();
    srst_in = 1'b0;
    new_reading();
    wait_flag(gap);
    new_reading();
    wait_flag(gap);
    chk(gap, 2 * BASE);
    show(8'h00);
    w = 0;
    while (flag_out === 1'b1 && w < 50) begin
      tick();
      w++;
    end
    chk(w + 4, FLAGW);
    rate_in = 6'd35;
    wait_flag(gap);
    wait_flag(gap);
    chk(gap, 35 * BASE);
    new_reading();
    wait_flag(gap);
    for (int g = 0; g < 8; g++) show(~(8'h01 << g));
    show(8'hfc);
    show(8'hff);
    show(lfsr[7:0]);
    strobe_n_in = 8'hff;
    {disp_hold_n_in, zero_chk_n_in, man_range_n_in} = 3'h0;
    range_sel_in = 3'h5;
    repeat (4) tick();
    chk({disp_hold_out, zero_chk_out, man_range_out, range_out},
        32'h3d);
    {disp_hold_n_in, zero_chk_n_in, man_range_n_in} = 3'h7;
    range_sel_in = 3'h2;
    repeat (4) tick();
    chk({disp_hold_out, zero_chk_out, man_range_out, range_out},
        32'h02);
    out_hold_n_in = 1'b0;
    new_reading();
    wait_flag(gap);
    chk(gap, 800);
    show(8'h00);
    out_hold_n_in = 1'b1;
    new_reading();
    wait_flag(gap);
    show(8'h00);
    rate_in = 6'd1;
    wait_flag(gap);
    wait_flag(gap);
    chk(gap, BASE);
    complete_run();
  end
endmodule : strobed_bcd_reading_output_test
